// >>> core/fault_reg_pkg.sv
// ****************************************************************
// fault register bank constants and types
// ****************************************************************
package fault_reg_pkg;

    // register offsets on the control port
    localparam logic [7:0] OFS_CHANNEL_FAULT  = 8'h70;
    localparam logic [7:0] OFS_GLOBAL_FAULT_A = 8'h71;
    localparam logic [7:0] OFS_GLOBAL_FAULT_B = 8'h72;
    localparam logic [7:0] OFS_TEMP_WARNING   = 8'h73;
    localparam logic [7:0] OFS_REPORT_MASK    = 8'h74;
    localparam logic [7:0] OFS_LATCH_CONTROL  = 8'h75;
    localparam logic [7:0] OFS_MISC_CONTROL   = 8'h76;
    localparam logic [7:0] OFS_FAULT_CLEAR    = 8'h78;

    // reset values
    localparam logic [7:0] RST_REPORT_MASK    = 8'h00;
    localparam logic [7:0] RST_LATCH_CONTROL  = 8'hf8;
    localparam logic [7:0] RST_MISC_CONTROL   = 8'h00;
    localparam logic [7:0] RST_FAULT_CLEAR    = 8'h00;

    // channel fault register fields
    localparam int BIT_LEFT_DC    = 3;
    localparam int BIT_RIGHT_DC   = 2;
    localparam int BIT_LEFT_OC    = 1;
    localparam int BIT_RIGHT_OC   = 0;
    // global fault a fields
    localparam int BIT_CRC_ERROR  = 7;
    localparam int BIT_COEF_FAIL  = 6;
    localparam int BIT_CLOCK      = 2;
    localparam int BIT_PWR_OV     = 1;
    localparam int BIT_PWR_UV     = 0;
    // global fault b and warning fields
    localparam int BIT_THERM_SD   = 0;
    localparam int BIT_THERM_WARN = 2;
    // report mask fields
    localparam int MSK_THERM_SD   = 7;
    localparam int MSK_CORE_UV    = 6;
    localparam int MSK_CORE_OV    = 5;
    localparam int MSK_CLOCK      = 4;
    localparam int MSK_PWR_UV     = 3;
    localparam int MSK_PWR_OV     = 2;
    localparam int MSK_DC         = 1;
    localparam int MSK_OC         = 0;
    // latch control fields
    localparam int LAT_CLOCK      = 5;
    localparam int LAT_THERM_SD   = 4;
    localparam int LAT_THERM_WARN = 3;
    localparam int MSK_THERM_WARN = 2;
    // misc control and clear fields
    localparam int MISC_DET_HOLD  = 7;
    localparam int MISC_AUTO_REC  = 4;
    localparam int CLR_ANALOG     = 7;

    // raw fault causes from the analog and digital monitors
    typedef struct packed {
        logic left_dc;
        logic right_dc;
        logic left_oc;
        logic right_oc;
        logic crc_error;
        logic coef_fail;
        logic clock_fault;
        logic pwr_ov;
        logic pwr_uv;
        logic core_ov;
        logic core_uv;
        logic therm_sd;
        logic therm_warn;
    } fault_cause_t;

    // control port register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : fault_reg_pkg

// >>> core/amp_fault_status_mask.sv
`timescale 1ns/1ps
module amp_fault_status_mask
    import fault_reg_pkg::*;
(
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rstn,
    // control port register access
    input  wire fault_reg_pkg::reg_req_t    req,
    output logic [7:0]                      rdata,
    output logic                            rvalid,
    // fault causes from monitors
    input  wire fault_reg_pkg::fault_cause_t cause,
    input  wire logic                       clock_detect,
    // outputs to the rest of the device
    output logic                            fault_report,
    output logic                            clock_detect_status,
    output logic                            therm_shutdown_active
);
    import fault_reg_pkg::*;

    // ****************************************************************
    // control registers
    // ****************************************************************
    // the host reaches three read-write control registers and one
    // write-only command; everything else on the port is status.
    // writes land on the edge that takes the strobe, so a read in
    // the same cycle still returns the old contents.
    // reserved bits of the control registers are stored as written;
    // the latch control keeps its upper pair at one after reset
    // because software may read them back and expect that value.
    // offsets outside the map are ignored on write, which keeps a
    // mistyped address from disturbing a live mask.
    // the clear command is decoded straight from the port, so it acts
    // on the very edge that takes the write, with no extra latency.
    logic [7:0] fault_report_mask;           // mask of fault reports
    logic [7:0] fault_latch_control;         // latch enables, warning mask
    logic [7:0] misc_fault_control;          // detect hold, auto recovery
    logic [7:0] next_fault_report_mask;
    logic [7:0] next_fault_latch_control;
    logic [7:0] next_misc_fault_control;
    logic       clear_pulse;                 // one-cycle analog clear

    // the clear bit is write-only; it never stores, so it reads zero
    assign clear_pulse = req.wr && (req.addr == OFS_FAULT_CLEAR)
                         && req.wdata[CLR_ANALOG];

    // next control values from host writes
    always_comb begin
        next_fault_report_mask   = fault_report_mask;
        next_fault_latch_control = fault_latch_control;
        next_misc_fault_control  = misc_fault_control;
        if (req.wr) begin
            if (req.addr == OFS_REPORT_MASK) begin
                next_fault_report_mask = req.wdata;
            end else if (req.addr == OFS_LATCH_CONTROL) begin
                next_fault_latch_control = req.wdata;
            end else if (req.addr == OFS_MISC_CONTROL) begin
                next_misc_fault_control = req.wdata;
            end
            // status register writes fall through: no effect
        end
    end

    // control register storage
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fault_report_mask   <= RST_REPORT_MASK;
            fault_latch_control <= RST_LATCH_CONTROL;
            misc_fault_control  <= RST_MISC_CONTROL;
        end else begin
            fault_report_mask   <= next_fault_report_mask;
            fault_latch_control <= next_fault_latch_control;
            misc_fault_control  <= next_misc_fault_control;
        end
    end

    // ****************************************************************
    // fault flag capture
    // ****************************************************************
    // each fault keeps one register bit; the raw causes arrive as
    // levels already in the core clock domain, so no synchroniser.
    // sticky bits hold a fault after its cause is gone, so a short
    // glitch that spans a clock edge is never lost between two host polls.
    // the clear and a fresh cause may meet in one cycle; the cause
    // wins, otherwise a fault present during the clear would vanish.
    // memory check and coefficient status are not analog faults and
    // follow their source directly; the clear does not touch them.
    // a limitation: a cause that rises and falls between two clock edges is not seen.
    // clock, shutdown and warning latch only while their enable is
    // set; with it cleared they simply mirror the monitor level.
    // reserved bits of global fault a are never loaded and read zero.
    logic [3:0] chan_flags;       // left dc, right dc, left oc, right oc
    logic [7:0] glob_a;           // global fault a image
    logic       therm_sd_flag;    // thermal shutdown flag
    logic       therm_warn_flag;  // thermal warning flag
    logic       det_status;       // clock detect status
    logic [3:0] next_chan_flags;
    logic [7:0] next_glob_a;
    logic       next_therm_sd_flag;
    logic       next_therm_warn_flag;
    logic       next_det_status;
    logic       sd_auto_rec;      // auto recovery clears shutdown

    // sticky flag: a cause seen in the clear cycle wins over the clear
    function automatic logic sticky(input logic flag, input logic src,
                                    input logic clr);
        sticky = src | (flag & ~clr);
    endfunction : sticky

    assign sd_auto_rec = misc_fault_control[MISC_AUTO_REC];

    // next flag values
    always_comb begin
        next_chan_flags[BIT_LEFT_DC]  = sticky(chan_flags[BIT_LEFT_DC],
                                        cause.left_dc, clear_pulse);
        next_chan_flags[BIT_RIGHT_DC] = sticky(chan_flags[BIT_RIGHT_DC],
                                        cause.right_dc, clear_pulse);
        next_chan_flags[BIT_LEFT_OC]  = sticky(chan_flags[BIT_LEFT_OC],
                                        cause.left_oc, clear_pulse);
        next_chan_flags[BIT_RIGHT_OC] = sticky(chan_flags[BIT_RIGHT_OC],
                                        cause.right_oc, clear_pulse);
        next_glob_a = 8'h00;
        // memory check and coefficient status track their sources
        next_glob_a[BIT_CRC_ERROR] = cause.crc_error;
        next_glob_a[BIT_COEF_FAIL] = cause.coef_fail;
        // clock fault latches only when enabled, else tracks live
        if (fault_latch_control[LAT_CLOCK]) begin
            next_glob_a[BIT_CLOCK] = sticky(glob_a[BIT_CLOCK],
                                     cause.clock_fault, clear_pulse);
        end else begin
            next_glob_a[BIT_CLOCK] = cause.clock_fault;
        end
        next_glob_a[BIT_PWR_OV] = sticky(glob_a[BIT_PWR_OV],
                                  cause.pwr_ov, clear_pulse);
        next_glob_a[BIT_PWR_UV] = sticky(glob_a[BIT_PWR_UV],
                                  cause.pwr_uv, clear_pulse);
        // shutdown latches when enabled unless auto recovery lets it follow the cause
        if (fault_latch_control[LAT_THERM_SD] && !sd_auto_rec) begin
            next_therm_sd_flag = sticky(therm_sd_flag, cause.therm_sd,
                                        clear_pulse);
        end else begin
            next_therm_sd_flag = cause.therm_sd;
        end
        if (fault_latch_control[LAT_THERM_WARN]) begin
            next_therm_warn_flag = sticky(therm_warn_flag,
                                   cause.therm_warn, clear_pulse);
        end else begin
            next_therm_warn_flag = cause.therm_warn;
        end
        // clock detect: hold while enabled, else follow the detector
        if (misc_fault_control[MISC_DET_HOLD]) begin
            next_det_status = det_status;
        end else begin
            next_det_status = clock_detect;
        end
    end

    // flag storage
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            chan_flags      <= 4'h0;
            glob_a          <= 8'h00;
            therm_sd_flag   <= 1'b0;
            therm_warn_flag <= 1'b0;
            det_status      <= 1'b0;
        end else begin
            chan_flags      <= next_chan_flags;
            glob_a          <= next_glob_a;
            therm_sd_flag   <= next_therm_sd_flag;
            therm_warn_flag <= next_therm_warn_flag;
            det_status      <= next_det_status;
        end
    end

    // ****************************************************************
    // report masking
    // ****************************************************************
    // masks only hide a fault from the report line; the status bits
    // still show it, so the host can poll a masked fault at will.
    // the report is registered to keep glitches of the or tree off
    // the pin; it trails the status bits by one cycle.
    // core rail faults have no status bit of their own and reach
    // the host only through the report line.
    // the warning mask lives in the latch control register, not in
    // the main mask register, so both must be written to hide all.
    // both channels share one dc mask and one overcurrent mask; a
    // trade-off that saves bits but cannot hide a single channel.
    // unmasking a fault that is still latched raises the report on the edge after the mask write lands.
    logic next_fault_report;   // combined unmasked fault
    logic core_uv_flag;        // core supply faults have no status bit
    logic core_ov_flag;
    logic next_core_uv_flag;
    logic next_core_ov_flag;

    // core rail faults are sticky too, cleared by the analog clear
    always_comb begin
        next_core_uv_flag = sticky(core_uv_flag, cause.core_uv, clear_pulse);
        next_core_ov_flag = sticky(core_ov_flag, cause.core_ov, clear_pulse);
        next_fault_report =
              (therm_sd_flag   & ~fault_report_mask[MSK_THERM_SD])
            | (core_uv_flag    & ~fault_report_mask[MSK_CORE_UV])
            | (core_ov_flag    & ~fault_report_mask[MSK_CORE_OV])
            | (glob_a[BIT_CLOCK] & ~fault_report_mask[MSK_CLOCK])
            | (glob_a[BIT_PWR_UV] & ~fault_report_mask[MSK_PWR_UV])
            | (glob_a[BIT_PWR_OV] & ~fault_report_mask[MSK_PWR_OV])
            | ((chan_flags[BIT_LEFT_DC] | chan_flags[BIT_RIGHT_DC])
               & ~fault_report_mask[MSK_DC])
            | ((chan_flags[BIT_LEFT_OC] | chan_flags[BIT_RIGHT_OC])
               & ~fault_report_mask[MSK_OC])
            | (therm_warn_flag & ~fault_latch_control[MSK_THERM_WARN]);
    end

    // report and side-state registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            core_uv_flag <= 1'b0;
            core_ov_flag <= 1'b0;
            fault_report <= 1'b0;
        end else begin
            core_uv_flag <= next_core_uv_flag;
            core_ov_flag <= next_core_ov_flag;
            fault_report <= next_fault_report;
        end
    end

    assign clock_detect_status   = det_status;
    assign therm_shutdown_active = therm_sd_flag;

    // ****************************************************************
    // read path
    // ****************************************************************
    // the read mux looks at the address every cycle, but the data
    // register only loads on a read strobe, so rdata holds the last
    // answer for as long as the host needs it.
    // unmapped offsets read zero rather than the last value, so a
    // wrong address shows up plainly instead of looking plausible.
    // the command register reads zero because its bit never stores.
    // rvalid is a one-cycle echo of the strobe, one edge late.
    // reading a status register has no side effect: polling never
    // clears a flag, only the clear command does that.
    // a write and a read in one cycle both act; the read sees old data.
    logic [7:0] next_rdata;

    // read mux; reserved status bits and unmapped offsets read zero
    always_comb begin
        next_rdata = 8'h00;
        if (req.addr == OFS_CHANNEL_FAULT) begin
            next_rdata[3:0] = chan_flags;
        end else if (req.addr == OFS_GLOBAL_FAULT_A) begin
            next_rdata = glob_a;
        end else if (req.addr == OFS_GLOBAL_FAULT_B) begin
            next_rdata[BIT_THERM_SD] = therm_sd_flag;
        end else if (req.addr == OFS_TEMP_WARNING) begin
            next_rdata[BIT_THERM_WARN] = therm_warn_flag;
        end else if (req.addr == OFS_REPORT_MASK) begin
            next_rdata = fault_report_mask;
        end else if (req.addr == OFS_LATCH_CONTROL) begin
            next_rdata = fault_latch_control;
        end else if (req.addr == OFS_MISC_CONTROL) begin
            next_rdata = misc_fault_control;
        end else if (req.addr == OFS_FAULT_CLEAR) begin
            next_rdata = RST_FAULT_CLEAR;
        end
    end

    // read data registered one cycle after the read strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rdata  <= req.rd ? next_rdata : rdata;
            rvalid <= req.rd;
        end
    end

endmodule : amp_fault_status_mask

// >>> tb/fault_host.sv
`timescale 1ns/1ps
// **************
// host on the control port
// **************
module fault_host
    import fault_reg_pkg::*;
(
    // clock
    input  wire logic                 ref_clk,
    // register requests towards the bank
    output fault_reg_pkg::reg_req_t   req
);
    // strobes low from time zero
    initial req = '0;

    // one access: strobe stands for exactly one sampling edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) req <= {w, ~w, a, d};
        // idle address and data are scrambled so stale values never pass
        @(posedge ref_clk) req <= {2'b00, 16'($urandom)};
    endtask : acc

    // write one to the clear bit to drop the latched analog faults
    task automatic clr();
        acc(1'b1, OFS_FAULT_CLEAR, 8'h80);
    endtask : clr
endmodule : fault_host

// >>> tb/amp_fault_status_mask_assertions.sv
`timescale 1ns/1ps
// **************
// port checks on the fault bank
// **************
module fault_bank_checker
    import fault_reg_pkg::*;
(
    // clock and reset
    input wire logic                        ref_clk,
    input wire logic                        rstn,
    // control port
    input wire fault_reg_pkg::reg_req_t     req,
    input wire logic [7:0]                  rdata,
    input wire logic                        rvalid,
    // monitor causes
    input wire fault_reg_pkg::fault_cause_t cause,
    input wire logic                        clock_detect,
    // device outputs
    input wire logic                        fault_report,
    input wire logic                        clock_detect_status,
    input wire logic                        therm_shutdown_active
);
    // any raw cause, kept as a signal so $past sees a plain net
    logic any_cause;
    assign any_cause = |cause;
    // a host write of the clear command, seen on the port
    logic clr_seen;
    assign clr_seen = req.wr && (req.addr == OFS_FAULT_CLEAR) && req.wdata[CLR_ANALOG];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    read_valid_a: assert property (1'b1 |=> rvalid == $past(req.rd))
        else $error("rvalid does not follow the read strobe");
    crc_live_a: assert property (req.rd && req.addr == OFS_GLOBAL_FAULT_A
        |=> rdata[7] == $past(cause.crc_error, 2)) else $error("crc flag wrong");
    coef_live_a: assert property (req.rd && req.addr == OFS_GLOBAL_FAULT_A
        |=> rdata[6] == $past(cause.coef_fail, 2)) else $error("coef flag wrong");
    chan_spare_a: assert property (req.rd && req.addr == OFS_CHANNEL_FAULT
        |=> rdata[7:4] == 4'h0) else $error("channel spare bits set");
    glob_spare_a: assert property (req.rd && req.addr == OFS_GLOBAL_FAULT_B
        |=> rdata[7:1] == 7'h00) else $error("global b spare bits set");
    warn_spare_a: assert property (req.rd && req.addr == OFS_TEMP_WARNING
        |=> (rdata & 8'hfb) == 8'h00) else $error("warning spare bits set");
    clear_wo_a: assert property (req.rd && req.addr == OFS_FAULT_CLEAR
        |=> rdata == 8'h00) else $error("clear register readable");
    dc_sticky_a: assert property (req.rd && req.addr == OFS_CHANNEL_FAULT
        && $past(cause.left_dc, 2) && !$past(clr_seen) |=> rdata[3])
        else $error("dc flag missing");
    det_change_a: assert property ($changed(clock_detect_status)
        |-> clock_detect_status == $past(clock_detect)) else $error("detect status jumped");
    sd_flag_a: assert property (cause.therm_sd |=> therm_shutdown_active)
        else $error("shutdown flag not set");
    report_cause_a: assert property ($rose(fault_report)
        |-> $past(any_cause, 2) || $past(req.wr, 2)) else $error("report without cause");
endmodule : fault_bank_checker

bind amp_fault_status_mask fault_bank_checker chk_u (.ref_clk(ref_clk), .rstn(rstn),
    .req(req), .rdata(rdata), .rvalid(rvalid), .cause(cause), .clock_detect(clock_detect),
    .fault_report(fault_report), .clock_detect_status(clock_detect_status),
    .therm_shutdown_active(therm_shutdown_active));

// >>> tb/amp_fault_status_mask_tb.sv
`timescale 1ns/1ps
module amp_fault_status_mask_tb;
    import fault_reg_pkg::*;
    // **************
    // signals
    // **************
    logic                     ref_clk = 1'b0;
    logic                     rstn;
    fault_reg_pkg::reg_req_t  req;
    logic [7:0]               rdata;
    logic                     rvalid;
    fault_reg_pkg::fault_cause_t cause;
    logic                     clock_detect;
    logic                     fault_report;
    logic                     clock_detect_status;
    logic                     therm_shutdown_active;
    int                       n_mismatch = 0;
    int                       n_compared = 0;
    int                       cycles = 0;
    logic [7:0]               exp_q [$];
    // cause bit, register, expected read
    logic [19:0] flag_tab [11] = '{20'hc7008, 20'hb7004, 20'ha7002, 20'h97001,
        20'h67104, 20'h57102, 20'h47101, 20'h37700, 20'h27700, 20'h17201, 20'h07304};

    always #12.5 ref_clk = ~ref_clk;

    fault_host host_u (.ref_clk(ref_clk), .req(req));
    amp_fault_status_mask dut_u (.ref_clk(ref_clk), .rstn(rstn), .req(req),
        .rdata(rdata), .rvalid(rvalid), .cause(cause), .clock_detect(clock_detect),
        .fault_report(fault_report), .clock_detect_status(clock_detect_status),
        .therm_shutdown_active(therm_shutdown_active));

    // **************
    // checking
    // **************
    task automatic final_report();
        if (exp_q.size() > 0) begin
            n_mismatch++;
            $display("wrong value at %0t: read left unanswered", $time);
        end
        if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk_rd

    // levels are looked at once the edge's updates have landed:
    // sel 0 report line, 1 clock detect status, 2 shutdown flag
    task automatic chk_lvl(input int sel, input logic exp);
        logic got;
        #1;
        got = (sel == 0) ? fault_report
            : (sel == 1) ? clock_detect_status : therm_shutdown_active;
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: level %b expected %b", $time, got, exp);
        end
    endtask : chk_lvl

    // note the expected answer, then issue the read
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        host_u.acc(1'b0, a, 8'h00);
    endtask : rd

    // one-cycle cause pulse, enough to set a sticky flag
    task automatic pulse(input int i);
        @(posedge ref_clk) cause[i] <= 1'b1;
        @(posedge ref_clk) cause[i] <= 1'b0;
    endtask : pulse

    // answers are matched in issue order; the cycle ceiling cuts a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (rvalid === 1'b1 && exp_q.size() > 0) chk_rd(rdata, exp_q.pop_front());
        else if (rvalid === 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: answer without a read", $time);
        end
        if (cycles > 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    // **************
    // scenarios
    // **************
    initial begin
        logic [7:0] d;
        rstn = 1'b0;
        cause = '0;
        clock_detect = 1'b0;
        void'($urandom(32'hd8d0));
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        // reset values, the hole at 0x77 included
        for (int a = 8'h70; a <= 8'h78; a++) rd(8'(a), (a == 8'h75) ? 8'hf8 : 8'h00);
        for (int a = 8'h74; a <= 8'h76; a++) begin
            d = 8'($urandom);
            host_u.acc(1'b1, 8'(a), d);
            rd(8'(a), d);
        end
        host_u.acc(1'b1, 8'h74, 8'h00);
        host_u.acc(1'b1, 8'h75, 8'hf8);
        host_u.acc(1'b1, 8'h76, 8'h00);
        // status and command writes must not stick
        host_u.acc(1'b1, 8'h70, 8'hff);
        rd(8'h70, 8'h00);
        host_u.acc(1'b1, 8'h78, 8'h7f);
        rd(8'h78, 8'h00);
        // sticky flags survive their cause until the clear write
        foreach (flag_tab[k]) begin
            pulse(int'(flag_tab[k][19:16]));
            rd(flag_tab[k][15:8], flag_tab[k][7:0]);
            chk_lvl(0, 1'b1);
            if (k == 9) chk_lvl(2, 1'b1);
            host_u.clr();
            rd(flag_tab[k][15:8], 8'h00);
            chk_lvl(0, 1'b0);
            if (k == 9) chk_lvl(2, 1'b0);
        end
        // crc and coefficient flags follow their cause
        for (int i = 7; i <= 8; i++) begin
            @(posedge ref_clk) cause[i] <= 1'b1;
            rd(8'h71, (i == 8) ? 8'h80 : 8'h40);
            @(posedge ref_clk) cause[i] <= 1'b0;
            repeat (2) @(posedge ref_clk);
            rd(8'h71, 8'h00);
        end
        // every maskable cause hidden from the report
        host_u.acc(1'b1, 8'h74, 8'hff);
        host_u.acc(1'b1, 8'h75, 8'hfc);
        for (int i = 0; i <= 12; i++) if (i < 7 || i > 8) begin
            pulse(i);
            repeat (2) @(posedge ref_clk);
            chk_lvl(0, 1'b0);
        end
        host_u.clr();
        host_u.acc(1'b1, 8'h74, 8'h00);
        // latch enables off: clock, shutdown and warning track their cause
        host_u.acc(1'b1, 8'h75, 8'h00);
        foreach (flag_tab[k]) if (k inside {4, 9, 10}) begin
            pulse(int'(flag_tab[k][19:16]));
            rd(flag_tab[k][15:8], 8'h00);
        end
        host_u.acc(1'b1, 8'h75, 8'hf8);
        // auto recovery lets the shutdown flag drop by itself
        host_u.acc(1'b1, 8'h76, 8'h10);
        pulse(1);
        rd(8'h72, 8'h00);
        chk_lvl(2, 1'b0);
        // clock detect live, then held
        host_u.acc(1'b1, 8'h76, 8'h00);
        @(posedge ref_clk) clock_detect <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk_lvl(1, 1'b1);
        host_u.acc(1'b1, 8'h76, 8'h80);
        @(posedge ref_clk) clock_detect <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_lvl(1, 1'b1);
        host_u.acc(1'b1, 8'h76, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk_lvl(1, 1'b0);
        repeat (4) @(posedge ref_clk);
        final_report();
    end
endmodule : amp_fault_status_mask_tb
